/* File: design/rx_error_counters.sv */
// Receive path, frame sync loss and far-end block error counters.
`timescale 1ns/1ps
// How it works
// - ESF: count each failed CRC6 codeword.
// - D4: count each Ft framing bit error.
// - D4 with Fs enable: count Fs errors too.
// - T1 path counter holds while sync lost.
// - E1: path counter counts each CRC4 error.
// - E1 path stops on FAS/CRC4 loss, not CAS.
// - Path count 16 bits, high 44h, low 45h.
// - T1 out-of-sync mode counts multiframes out of sync.
// - Multiframe counting continues during sync loss.
// - T1 F-bit mode counts Ft (D4) or FPS (ESF).
// - T1 F-bit mode stops during sync loss.
// - E1: frame counter counts FAS word errors.
// - E1 frame counter stops while sync lost.
// - E1 ignores FAS errors during alignment search.
// - Frame count 16 bits, high 46h, low 47h.
// - E-bit counter counts in E1 only.
// - CRC4 multiframe: count each zero E-bit.
// - E-bit stops on FAS/CRC4 loss, not CAS.
// - E-bit count 16 bits, high 48h, low 49h.
// - Counters saturate at maximum, never wrap.
// - Auto update each second, or 42/62.5 ms.
// - Manual bit rising edge latches and clears.
module rx_error_counters #(
  parameter int unsigned ONE_SECOND_CYCLES =
    err_count_pkg::ONE_SECOND_CYCLES,
  parameter int unsigned T1_FAST_CYCLES    =
    err_count_pkg::T1_FAST_CYCLES,
  parameter int unsigned E1_FAST_CYCLES    =
    err_count_pkg::E1_FAST_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Line mode.
  input  wire logic                 e1_mode,
  input  wire logic                 esf_mode,
  // Counter update configuration bits.
  input  wire logic                 fs_error_report_enable,
  input  wire logic                 sync_loss_function_select,
  input  wire logic                 auto_update_interval_select,
  input  wire logic                 manual_update_trigger,
  input  wire logic                 accumulation_mode_select,
  // Receive synchronizer state.
  input  wire logic                 receive_sync_lost_flag,
  input  wire logic                 fas_sync_lost,
  input  wire logic                 crc4_sync_lost,
  input  wire logic                 fas_search_active,
  input  wire logic                 multiframe_search_active,
  input  wire logic                 crc4_multiframe_enable,
  // Error events, one cycle each.
  input  wire logic                 crc6_error,
  input  wire logic                 ft_error,
  input  wire logic                 fs_error,
  input  wire logic                 fps_error,
  input  wire logic                 multiframe_sync_loss,
  input  wire logic                 crc4_error,
  input  wire logic                 fas_word_error,
  input  wire logic                 ebit_zero,
  // Register read port.
  input  wire err_count_pkg::addr_t reg_addr,
  input  wire logic                 reg_rd,
  output err_count_pkg::byte_t      reg_rdata,
  output logic                      reg_rdata_valid,
  output logic                      reg_addr_hit,
  // Status.
  output logic                      counts_updated,
  output logic                      counts_settled,
  output logic [2:0]                count_saturated
);

  localparam int N = err_count_pkg::NUM_COUNTERS;

  logic [N-1:0]          inc;
  logic [N-1:0]          sat;
  err_count_pkg::count_t count_w    [N];
  err_count_pkg::count_t snapshot_q [N];

  logic                  path_inc;
  logic                  frame_inc;
  logic                  ebit_inc;
  logic                  e1_frame_sync_ok;

  err_count_pkg::timer_t interval_limit;
  err_count_pkg::timer_t limit_q;
  err_count_pkg::timer_t timer_q;
  logic                  auto_tick;
  logic                  manual_edge;
  logic                  trigger_q;
  logic                  update;

  err_count_pkg::settle_t settle_q;
  err_count_pkg::byte_t   rdata_q;
  logic                   rdata_valid_q;
  logic                   updated_q;
  err_count_pkg::byte_t   read_byte;
  logic                   read_hit;

  // E1 framing is trusted only with both FAS and CRC4 alignment held;
  // loss of CAS multiframe alignment alone does not stop counting.
  assign e1_frame_sync_ok = !fas_sync_lost && !crc4_sync_lost;

  // Path violation counter qualification.
  always_comb begin
    path_inc = 1'b0;
    if (e1_mode) begin
      path_inc = crc4_error && e1_frame_sync_ok;
    end else if (!receive_sync_lost_flag) begin
      if (esf_mode) begin
        path_inc = crc6_error;
      end else begin
        path_inc = ft_error || (fs_error_report_enable && fs_error);
      end
    end
  end

  // Frame sync loss counter qualification.
  always_comb begin
    frame_inc = 1'b0;
    if (e1_mode) begin
      if (!receive_sync_lost_flag &&
          !fas_search_active && !multiframe_search_active) begin
        frame_inc = fas_word_error;
      end
    end else if (sync_loss_function_select) begin
      frame_inc = multiframe_sync_loss;
    end else if (!receive_sync_lost_flag) begin
      frame_inc = esf_mode ? fps_error : ft_error;
    end
  end

  // Far-end block error counter qualification.
  always_comb begin
    ebit_inc = 1'b0;
    if (e1_mode && crc4_multiframe_enable) begin
      ebit_inc = ebit_zero && e1_frame_sync_ok;
    end
  end

  assign inc[err_count_pkg::IDX_PATH]  = path_inc;
  assign inc[err_count_pkg::IDX_FRAME] = frame_inc;
  assign inc[err_count_pkg::IDX_EBIT]  = ebit_inc;

  // Automatic interval length for the current line mode.
  always_comb begin
    if (!auto_update_interval_select) begin
      interval_limit = err_count_pkg::timer_t'(ONE_SECOND_CYCLES);
    end else if (e1_mode) begin
      interval_limit = err_count_pkg::timer_t'(E1_FAST_CYCLES);
    end else begin
      interval_limit = err_count_pkg::timer_t'(T1_FAST_CYCLES);
    end
  end

  assign auto_tick = !accumulation_mode_select &&
                     (timer_q == interval_limit - err_count_pkg::TIMER_ONE);

  // Interval timer restarts whenever the interval choice changes, so a
  // shortened interval never runs past its own end.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_q <= err_count_pkg::TIMER_RESET;
      limit_q <= err_count_pkg::TIMER_RESET;
    end else begin
      limit_q <= interval_limit;
      if (accumulation_mode_select || auto_tick ||
          (interval_limit != limit_q)) begin
        timer_q <= err_count_pkg::TIMER_RESET;
      end else begin
        timer_q <= timer_q + err_count_pkg::TIMER_ONE;
      end
    end
  end

  // Manual trigger edge detection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trigger_q <= 1'b0;
    end else begin
      trigger_q <= manual_update_trigger;
    end
  end

  assign manual_edge = accumulation_mode_select &&
                       manual_update_trigger && !trigger_q;

  assign update = accumulation_mode_select ? manual_edge : auto_tick;

  // One saturating counter per error kind.
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_cnt
      sat_counter16 u_cnt (
        .clk       (clk),
        .rst_b     (rst_b),
        .inc       (inc[gi]),
        .clear     (update),
        .count     (count_w[gi]),
        .saturated (sat[gi])
      );

      // Both bytes of a count are read from this one snapshot.
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          snapshot_q[gi] <= err_count_pkg::COUNT_RESET;
        end else if (update) begin
          snapshot_q[gi] <= count_w[gi];
        end
      end
    end
  endgenerate

  // Settle window after an update, during which reads may be stale.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      settle_q <= err_count_pkg::SETTLE_RESET;
    end else if (update) begin
      settle_q <= err_count_pkg::MANUAL_SETTLE_CYCLES;
    end else if (settle_q != err_count_pkg::SETTLE_RESET) begin
      settle_q <= settle_q - err_count_pkg::SETTLE_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      updated_q <= 1'b0;
    end else begin
      updated_q <= update;
    end
  end

  // Byte decode of the readable count registers.
  always_comb begin
    read_byte = err_count_pkg::BYTE_RESET;
    read_hit  = 1'b1;
    case (reg_addr)
      err_count_pkg::ADDR_PATH_VIOLATION_HIGH: begin
        read_byte = snapshot_q[err_count_pkg::IDX_PATH][15:8];
      end
      err_count_pkg::ADDR_PATH_VIOLATION_LOW: begin
        read_byte = snapshot_q[err_count_pkg::IDX_PATH][7:0];
      end
      err_count_pkg::ADDR_FRAME_SYNC_LOSS_HIGH: begin
        read_byte = snapshot_q[err_count_pkg::IDX_FRAME][15:8];
      end
      err_count_pkg::ADDR_FRAME_SYNC_LOSS_LOW: begin
        read_byte = snapshot_q[err_count_pkg::IDX_FRAME][7:0];
      end
      err_count_pkg::ADDR_FAR_END_BLOCK_HIGH: begin
        read_byte = snapshot_q[err_count_pkg::IDX_EBIT][15:8];
      end
      err_count_pkg::ADDR_FAR_END_BLOCK_LOW: begin
        read_byte = snapshot_q[err_count_pkg::IDX_EBIT][7:0];
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  // Read data is registered; unmapped addresses return zero.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q       <= err_count_pkg::BYTE_RESET;
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= read_byte;
      end
    end
  end

  assign reg_rdata       = rdata_q;
  assign reg_rdata_valid = rdata_valid_q;
  assign reg_addr_hit    = read_hit;
  assign counts_updated  = updated_q;
  assign counts_settled  = (settle_q == err_count_pkg::SETTLE_RESET);
  assign count_saturated = sat;

endmodule : rx_error_counters

/* File: pkg/err_count_pkg.sv */
// Constants and types shared by the receive error counter block.
package err_count_pkg;

  // Count and register widths.
  localparam int CNT_W          = 16;
  localparam int BYTE_W         = 8;
  localparam int ADDR_W         = 8;
  localparam int NUM_COUNTERS   = 3;
  localparam int TIMER_W        = 26;
  localparam int SETTLE_W       = 2;

  typedef logic [CNT_W-1:0]    count_t;
  typedef logic [BYTE_W-1:0]   byte_t;
  typedef logic [ADDR_W-1:0]   addr_t;
  typedef logic [TIMER_W-1:0]  timer_t;
  typedef logic [SETTLE_W-1:0] settle_t;

  // Position of each counter in the counter vectors.
  localparam int IDX_PATH       = 0;
  localparam int IDX_FRAME      = 1;
  localparam int IDX_EBIT       = 2;

  // Byte addresses of the readable count registers.
  localparam addr_t ADDR_PATH_VIOLATION_HIGH  = 8'h44;
  localparam addr_t ADDR_PATH_VIOLATION_LOW   = 8'h45;
  localparam addr_t ADDR_FRAME_SYNC_LOSS_HIGH = 8'h46;
  localparam addr_t ADDR_FRAME_SYNC_LOSS_LOW  = 8'h47;
  localparam addr_t ADDR_FAR_END_BLOCK_HIGH   = 8'h48;
  localparam addr_t ADDR_FAR_END_BLOCK_LOW    = 8'h49;

  // Values after reset and limits.
  localparam count_t  COUNT_RESET  = 16'h0000;
  localparam count_t  COUNT_MAX    = 16'hFFFF;
  localparam count_t  COUNT_ONE    = 16'h0001;
  localparam byte_t   BYTE_RESET   = 8'h00;
  localparam timer_t  TIMER_RESET  = 26'h0000000;
  localparam timer_t  TIMER_ONE    = 26'h0000001;
  localparam settle_t SETTLE_RESET = 2'h0;
  localparam settle_t SETTLE_ONE   = 2'h1;

  // Clock rate and update intervals in their own units.
  localparam int  CLK_FREQ_HZ      = 50_000_000;
  localparam int  ONE_SECOND_MS    = 1000;
  localparam int  T1_FAST_MS       = 42;
  localparam real E1_FAST_MS       = 62.5;
  localparam real MANUAL_SETTLE_RX_CLOCKS = 1.5;

  // Interval lengths in clock cycles (longest times, rounded down).
  localparam int ONE_SECOND_CYCLES =
    ONE_SECOND_MS * (CLK_FREQ_HZ / 1000);
  localparam int T1_FAST_CYCLES    =
    T1_FAST_MS * (CLK_FREQ_HZ / 1000);
  localparam int E1_FAST_CYCLES    =
    $rtoi(E1_FAST_MS * (CLK_FREQ_HZ / 1000));

  // Cycles after an update before the snapshot is settled (rounded to nearest, plus one).
  localparam settle_t MANUAL_SETTLE_CYCLES =
    settle_t'($rtoi(MANUAL_SETTLE_RX_CLOCKS + 0.5) + 1);

endpackage : err_count_pkg

/* File: design/sat_counter16.sv */
// Saturating event counter with restart on clear.
`timescale 1ns/1ps
module sat_counter16 (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  inc,
  input  wire logic                  clear,
  output err_count_pkg::count_t      count,
  output logic                       saturated
);

  err_count_pkg::count_t count_q;
  err_count_pkg::count_t count_d;

  // An event in the clearing cycle becomes the first count of the next
  // interval, so no event is lost across an update.
  always_comb begin
    count_d = count_q;
    if (clear) begin
      count_d = inc ? err_count_pkg::COUNT_ONE : err_count_pkg::COUNT_RESET;
    end else if (inc && (count_q != err_count_pkg::COUNT_MAX)) begin
      count_d = count_q + err_count_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_q <= err_count_pkg::COUNT_RESET;
    end else begin
      count_q <= count_d;
    end
  end

  assign count     = count_q;
  assign saturated = (count_q == err_count_pkg::COUNT_MAX);

endmodule : sat_counter16

/* File: tb/line_event_source.sv */
// Receive line model that issues one-cycle framing error pulses.
`timescale 1ns/1ps
module line_event_source (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       go,
  input  wire logic       dense,
  input  wire logic [7:0] mask,
  output logic      [7:0] ev
);
  // Bits are crc6, ft, fs, fps, multiframe out of sync, crc4, fas word and
  // zero E-bit; each high cycle stands for one received event.
  always @(posedge clk) begin
    if (!rst_b || !go)
      ev <= 8'h00;
    else
      ev <= mask & (dense ? 8'hFF : 8'($urandom));
  end
endmodule : line_event_source

/* File: tb/rx_error_counters_properties.sv */
// Concurrent checks on the ports of the receive error counter block.
`timescale 1ns/1ps
module rx_error_counters_properties (
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire logic                 manual_update_trigger,
  input wire logic                 accumulation_mode_select,
  input wire err_count_pkg::addr_t reg_addr,
  input wire logic                 reg_rd,
  input wire err_count_pkg::byte_t reg_rdata,
  input wire logic                 reg_rdata_valid,
  input wire logic                 reg_addr_hit,
  input wire logic                 counts_updated,
  input wire logic                 counts_settled,
  input wire logic [2:0]           count_saturated
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_read_valid: assert property (reg_rd |=> reg_rdata_valid)
    else $error("read not answered in the next cycle");
  chk_valid_idle: assert property (!reg_rd |=> !reg_rdata_valid)
    else $error("read valid without a read");
  chk_unmapped_zero: assert property (
    reg_rd && !reg_addr_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_addr_decode: assert property (
    reg_addr_hit == (reg_addr >= 8'h44 && reg_addr <= 8'h49))
    else $error("address decode wrong");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_manual_update: assert property (
    accumulation_mode_select && $rose(manual_update_trigger)
    |=> counts_updated)
    else $error("manual edge gave no update");
  chk_manual_quiet: assert property (
    accumulation_mode_select && $past(accumulation_mode_select) &&
    !$rose(manual_update_trigger) |=> !counts_updated)
    else $error("update in manual mode without an edge");
  chk_settle_low: assert property (
    counts_updated |-> !counts_settled [*3])
    else $error("settled too early after update");
  chk_sat_hold: assert property (
    $fell(count_saturated[0]) |-> counts_updated)
    else $error("saturated path count left its maximum");
endmodule : rx_error_counters_properties
bind rx_error_counters rx_error_counters_properties u_props (
  .clk(clk), .rst_b(rst_b), .manual_update_trigger(manual_update_trigger),
  .accumulation_mode_select(accumulation_mode_select),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .reg_addr_hit(reg_addr_hit),
  .counts_updated(counts_updated), .counts_settled(counts_settled),
  .count_saturated(count_saturated));

/* File: tb/rx_error_counters_tb_top.sv */
// Self-checking bench for the receive error counter block.
`timescale 1ns/1ps
module rx_error_counters_tb_top;
  localparam int         SEC = 40;
  localparam int         T1F = 20;
  localparam int         E1F = 30;
  logic                  clk, rst_b, go, dense, trig, acc, ivl, reg_rd;
  logic                  valid, hit, upd, settled;
  logic [9:0]            cfg;
  logic [7:0]            mask, ev, reg_addr, hi, lo;
  logic [2:0]            sat;
  logic [15:0]           cnt;
  err_count_pkg::byte_t  reg_rdata;
  err_count_pkg::count_t exp_c [3];
  int                    n_fail, samples_checked, cyc, per;
  // Config bits: e1, esf, fs enable, mos select, sync lost, fas lost,
  // crc4 lost, fas search, multiframe search, crc4 multiframe.
  logic [9:0]            corner [8] = '{10'h000, 10'h004, 10'h206, 10'h018,
                                        10'h010, 10'h201, 10'h311, 10'h261};

  line_event_source u_line (.clk(clk), .rst_b(rst_b), .go(go),
    .dense(dense), .mask(mask), .ev(ev));
  rx_error_counters #(.ONE_SECOND_CYCLES(SEC), .T1_FAST_CYCLES(T1F),
    .E1_FAST_CYCLES(E1F)) u_dut (.clk(clk), .rst_b(rst_b),
    .e1_mode(cfg[0]), .esf_mode(cfg[1]), .fs_error_report_enable(cfg[2]),
    .sync_loss_function_select(cfg[3]), .auto_update_interval_select(ivl),
    .manual_update_trigger(trig), .accumulation_mode_select(acc),
    .receive_sync_lost_flag(cfg[4]), .fas_sync_lost(cfg[5]),
    .crc4_sync_lost(cfg[6]), .fas_search_active(cfg[7]),
    .multiframe_search_active(cfg[8]), .crc4_multiframe_enable(cfg[9]),
    .crc6_error(ev[0]), .ft_error(ev[1]), .fs_error(ev[2]),
    .fps_error(ev[3]), .multiframe_sync_loss(ev[4]), .crc4_error(ev[5]),
    .fas_word_error(ev[6]), .ebit_zero(ev[7]), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(valid),
    .reg_addr_hit(hit), .counts_updated(upd), .counts_settled(settled),
    .count_saturated(sat));

  function automatic logic [2:0] inc(logic [9:0] c, logic [7:0] e);
    logic pth, frm, eb;
    pth = c[0] ? e[5] & !c[5] & !c[6]
               : !c[4] & (c[1] ? e[0] : e[1] | (c[2] & e[2]));
    frm = c[0] ? e[6] & !c[4] & !c[7] & !c[8]
               : (c[3] ? e[4] : !c[4] & (c[1] ? e[3] : e[1]));
    eb = c[0] & c[9] & e[7] & !c[5] & !c[6];
    return {eb, frm, pth};
  endfunction : inc

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk("read valid", 16'h0001, {15'h0000, valid});
  endtask : rd

  task automatic rd16(logic [7:0] a, output logic [15:0] v);
    rd(a, hi);
    rd(a + 8'h01, lo);
    v = {hi, lo};
  endtask : rd16

  // The host waits five cycles after the manual edge before reading.
  task automatic run(logic [9:0] c, int n);
    logic [2:0] es;
    @(posedge clk);
    cfg <= c;
    go <= 1'b1;
    repeat (n) @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    trig <= 1'b1;
    #1;
    for (int k = 0; k < 3; k++)
      es[k] = (exp_c[k] == 16'hFFFF);
    chk("saturated", {13'h0000, es}, {13'h0000, sat});
    @(posedge clk);
    trig <= 1'b0;
    #1 chk("update pulse", 16'h0001, {15'h0000, upd});
    chk("settling", 16'h0000, {15'h0000, settled});
    repeat (4) @(posedge clk);
    #1 chk("settled", 16'h0001, {15'h0000, settled});
    rd16(8'h44, cnt);
    chk("path", exp_c[0], cnt);
    rd16(8'h46, cnt);
    chk("frame", exp_c[1], cnt);
    rd16(8'h48, cnt);
    chk("ebit", exp_c[2], cnt);
    exp_c = '{3{16'h0000}};
  endtask : run

  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (upd !== 1'b1 && n < 100);
  endtask : wait_upd

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 75000) begin
      n_fail++;
      end_of_test();
    end
  end

  always @(posedge clk) begin
    logic [2:0] d;
    d = inc(cfg, ev);
    for (int k = 0; k < 3; k++)
      if (rst_b && d[k] && exp_c[k] != 16'hFFFF)
        exp_c[k]++;
  end

  initial begin
    {rst_b, go, dense, trig, ivl, reg_rd} = 6'h00;
    acc = 1'b1;
    reg_addr = 8'h00;
    cfg = 10'h000;
    mask = 8'hFF;
    exp_c = '{3{16'h0000}};
    void'($urandom(32'haa32));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd(8'h44 + 8'(k), lo);
      chk("reset value", 16'h0000, {8'h00, lo});
    end
    foreach (corner[i]) begin
      rd(i[0] ? 8'h4A : 8'h43, lo);
      chk("unmapped hit", 16'h0000, {15'h0000, hit});
      run(corner[i], 20);
      $display("corner test %0d done", i);
    end
    for (int t = 0; t < 30; t++) begin
      run(10'($urandom), 1 + $urandom_range(40));
      $display("random test %0d done", t);
    end
    @(posedge clk);
    acc <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      cfg <= 10'(m[0]);
      ivl <= m[1];
      wait_upd(per);
      wait_upd(per);
      chk("interval", m[1] ? (m[0] ? E1F : T1F) : SEC, per);
    end
    $display("interval test done");
    @(posedge clk);
    acc <= 1'b1;
    dense <= 1'b1;
    mask <= 8'h01;
    run(10'h002, 65540);
    $display("saturation test done");
    end_of_test();
  end
endmodule : rx_error_counters_tb_top
